// ### verilog/nvd_pkg.sv
// Package of constants for the nonvolatile memory timing clock divider
`default_nettype none
package nvd_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_CLOCK_RATIO = 12'h000;
    localparam logic [11:0] ADDR_PULSE_COUNT = 12'h004;
    // Field positions of the divider register
    localparam int LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int RATIO_MSB = 5;
    // Values after reset
    localparam logic [5:0] RATIO_RESET = 6'h00;
    localparam logic PRESCALE_RESET = 1'b0;
    localparam logic [31:0] PULSE_COUNT_RESET = 32'h0000_0000;
    // Prescaler counts 0..7 for divide by 8
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [2:0] PRESCALE_RESET_CNT = 3'h0;
    localparam logic [5:0] DIV_RESET_CNT = 6'h00;
    // Operation lengths are counted in pulses; longest count width
    localparam int OP_PULSE_WIDTH = 16;
    localparam logic [15:0] OP_PULSE_RESET = 16'h0000;
    localparam logic [15:0] OP_PULSE_MIN = 16'h0001;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b10
    } nvd_state_t;
endpackage : nvd_pkg
`default_nettype wire

// ### verilog/nvd_clock_divider.sv
// Nonvolatile memory timing clock divider with APB register slave
// Function
// - The loaded flag is clear after reset and set by the first divider write, any data.
// - Prescale and ratio bits take only the first write after reset; reads work always.
// - Program and erase are blocked while the loaded flag is zero, allowed once one.
// - Prescale bit zero feeds the bus clock to the ratio divider, one feeds it divided by 8.
// - The (prescaled) clock is divided by the ratio field plus one to make the timing clock.
// - Each timing pulse is one bus clock cycle wide, except that prescale zero with ratio zero holds it high every cycle.
// - Each operation is timed as a whole number of timing pulses.
`default_nettype none
module nvd_clock_divider
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer side
    input wire logic opStart,
    input wire logic [15:0] opPulses,
    output logic opAllowed,
    output logic opBusy,
    output logic opDone,
    output logic timingPulse
);

    // Register state
    logic loaded_r, loaded_nxt;
    logic prescale_r, prescale_nxt;
    logic [5:0] ratio_r, ratio_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic pready_r, pready_nxt;
    logic [31:0] pulseCount_r, pulseCount_nxt;
    // Divider state
    logic [2:0] preCnt_r, preCnt_nxt;
    logic [5:0] divCnt_r, divCnt_nxt;
    logic pulse_r, pulse_nxt;
    // Sequencer state
    nvd_pkg::nvd_state_t state_r, state_nxt;
    logic [15:0] opLeft_r, opLeft_nxt;
    logic done_r, done_nxt;
    logic busy_r, busy_nxt;

    // Bus decode
    logic setupPhase;
    logic accessPhase;
    logic hitRatio;
    logic hitCount;
    logic ratioWrite;
    logic divTick;

    function automatic logic hitAddr(input logic [11:0] a, input logic [11:0] base);
        hitAddr = (a == base);
    endfunction : hitAddr

    // Answer in the first access cycle: pready high one cycle after setup
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable && pready_r;
    assign hitRatio = hitAddr(paddr, nvd_pkg::ADDR_CLOCK_RATIO);
    assign hitCount = hitAddr(paddr, nvd_pkg::ADDR_PULSE_COUNT);
    assign ratioWrite = accessPhase && pwrite && hitRatio;

    always_comb
    begin
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        pready_nxt = setupPhase;
        if (setupPhase)
        begin
            if (hitRatio)
            begin
                prdata_nxt = {24'h00_0000, loaded_r, prescale_r, ratio_r};
            end
            else if (hitCount)
            begin
                prdata_nxt = pulseCount_r;
            end
            else
            begin
                pslverr_nxt = 1'b1;
            end
        end
        else if (!accessPhase)
        begin
            prdata_nxt = prdata_r;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end
        else
        begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            pready_r <= pready_nxt;
        end
    end

    // Write-once divider register
    always_comb
    begin
        loaded_nxt = loaded_r;
        prescale_nxt = prescale_r;
        ratio_nxt = ratio_r;
        if (ratioWrite)
        begin
            if (!loaded_r)
            begin
                prescale_nxt = pwdata[nvd_pkg::PRESCALE_BIT];
                ratio_nxt = pwdata[nvd_pkg::RATIO_MSB:0];
            end
            loaded_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            loaded_r <= 1'b0;
            prescale_r <= nvd_pkg::PRESCALE_RESET;
            ratio_r <= nvd_pkg::RATIO_RESET;
        end
        else
        begin
            loaded_r <= loaded_nxt;
            prescale_r <= prescale_nxt;
            ratio_r <= ratio_nxt;
        end
    end

    // Prescaler, counts only while divide by 8 is selected
    always_comb
    begin
        preCnt_nxt = preCnt_r;
        if (!loaded_r)
        begin
            preCnt_nxt = nvd_pkg::PRESCALE_RESET_CNT;
        end
        else if (prescale_r)
        begin
            preCnt_nxt = preCnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            preCnt_r <= nvd_pkg::PRESCALE_RESET_CNT;
        end
        else
        begin
            preCnt_r <= preCnt_nxt;
        end
    end

    // Ratio divider; input tick is every clock or every eighth
    assign divTick = !prescale_r || (preCnt_r == nvd_pkg::PRESCALE_LAST);

    always_comb
    begin
        divCnt_nxt = divCnt_r;
        pulse_nxt = 1'b0;
        if (!loaded_r)
        begin
            divCnt_nxt = nvd_pkg::DIV_RESET_CNT;
        end
        else if (divTick)
        begin
            if (divCnt_r >= ratio_r)
            begin
                divCnt_nxt = nvd_pkg::DIV_RESET_CNT;
                pulse_nxt = 1'b1;
            end
            else
            begin
                divCnt_nxt = divCnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_r <= nvd_pkg::DIV_RESET_CNT;
            pulse_r <= 1'b0;
        end
        else
        begin
            divCnt_r <= divCnt_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // Pulse counter, read back at its own offset
    always_comb
    begin
        pulseCount_nxt = pulseCount_r;
        if (pulse_nxt)
        begin
            pulseCount_nxt = pulseCount_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pulseCount_r <= nvd_pkg::PULSE_COUNT_RESET;
        end
        else
        begin
            pulseCount_r <= pulseCount_nxt;
        end
    end

    // Operation timer counting whole pulses
    always_comb
    begin
        state_nxt = state_r;
        opLeft_nxt = opLeft_r;
        done_nxt = 1'b0;
        busy_nxt = busy_r;
        case (state_r)
            nvd_pkg::ST_IDLE:
            begin
                if (opStart && loaded_r)
                begin
                    // Zero length runs as a single pulse
                    if (opPulses == nvd_pkg::OP_PULSE_RESET)
                    begin
                        opLeft_nxt = nvd_pkg::OP_PULSE_MIN;
                    end
                    else
                    begin
                        opLeft_nxt = opPulses;
                    end
                    state_nxt = nvd_pkg::ST_RUN;
                    busy_nxt = 1'b1;
                end
            end
            nvd_pkg::ST_RUN:
            begin
                if (pulse_r)
                begin
                    opLeft_nxt = opLeft_r - 16'h0001;
                    if (opLeft_r == nvd_pkg::OP_PULSE_MIN)
                    begin
                        state_nxt = nvd_pkg::ST_DONE;
                        busy_nxt = 1'b0;
                    end
                end
            end
            nvd_pkg::ST_DONE:
            begin
                done_nxt = 1'b1;
                state_nxt = nvd_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = nvd_pkg::ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= nvd_pkg::ST_IDLE;
            opLeft_r <= nvd_pkg::OP_PULSE_RESET;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            opLeft_r <= opLeft_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign opAllowed = loaded_r;
    assign opBusy = busy_r;
    assign opDone = done_r;
    assign timingPulse = pulse_r;

endmodule : nvd_clock_divider
`default_nettype wire

// ### bench/nvd_clock_monitor.sv
// Port checker for the timing clock divider
`default_nettype none
module nvd_clock_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic opStart,
    input wire logic opAllowed,
    input wire logic opBusy,
    input wire logic opDone,
    input wire logic timingPulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence divWrite;
        psel && penable && pready && pwrite && paddr == nvd_pkg::ADDR_CLOCK_RATIO;
    endsequence
    ready_next_a: assert property (apbSetup |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer");
    loaded_set_a: assert property (divWrite |=> opAllowed)
        else $error("flag not set by write");
    loaded_keep_a: assert property (opAllowed |=> opAllowed)
        else $error("flag dropped");
    loaded_cause_a: assert property (!opAllowed && !divWrite |=> !opAllowed)
        else $error("flag set without write");
    gated_op_a: assert property (!opAllowed |-> !timingPulse && !opBusy)
        else $error("activity while not loaded");
    start_busy_a: assert property (opStart && opAllowed && !opBusy && !$past(opBusy)
        |=> opBusy)
        else $error("start not taken");
    busy_end_a: assert property (opBusy && !timingPulse |=> opBusy)
        else $error("operation ended off a pulse");
    done_once_a: assert property (opDone |-> !opBusy ##1 !opDone)
        else $error("done not single");
    read_flag_a: assert property (pready && !pwrite && paddr == nvd_pkg::ADDR_CLOCK_RATIO
        |-> prdata[31:7] == {24'h000000, opAllowed})
        else $error("bad flag readback");
    bad_addr_a: assert property (pready && paddr != nvd_pkg::ADDR_CLOCK_RATIO
        && paddr != nvd_pkg::ADDR_PULSE_COUNT |-> pslverr)
        else $error("unmapped not refused");
endmodule : nvd_clock_monitor
bind nvd_clock_divider nvd_clock_monitor mon (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .opStart, .opAllowed, .opBusy, .opDone, .timingPulse);
`default_nettype wire

// ### bench/nvd_seq_model.sv
// Program and erase sequencer model
`default_nettype none
module nvd_seq_model
(
    input wire logic clk,
    input wire logic kick,
    input wire logic [15:0] len,
    output logic opStart,
    output logic [15:0] opPulses
);
    timeunit 1ns;
    timeprecision 1ns;
    // Length shows its inverse when idle so a stale value is never taken
    always @(posedge clk)
    begin
        opStart <= kick;
        opPulses <= kick ? len : ~len;
    end
endmodule : nvd_seq_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the timing clock divider
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, kick = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, opStart, opAllowed, opBusy, opDone, timingPulse;
    logic [15:0] opPulses;
    logic [15:0] opLen = 16'h0003;
    logic [32:0] expQ[$];
    int n_errors = 0, samples_checked = 0, seed = 51728, cyc = 0;
    always #50 clk = ~clk;
    nvd_clock_divider dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .opStart, .opPulses, .opAllowed, .opBusy, .opDone, .timingPulse);
    nvd_seq_model partner (.clk, .kick, .len(opLen), .opStart, .opPulses);
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        expQ.push_back(exp);
        apb(1'b0, a, 32'h00000000);
    endtask : rd
    always @(posedge clk)
        if (psel && penable && !pwrite && pready === 1'b1)
            check({pslverr, prdata}, expQ.pop_front());
    task automatic print_verdict;
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        logic [5:0] r;
        int n;
        for (int p = 0; p < 2; p++)
        begin
            rst <= 1'b1;
            repeat (6) @(posedge clk);
            rst <= 1'b0;
            rd(nvd_pkg::ADDR_CLOCK_RATIO, 33'h000000000);
            kick <= 1'b1;
            @(posedge clk);
            kick <= 1'b0;
            repeat (3) @(posedge clk);
            check(33'({opBusy, opAllowed, timingPulse}), 33'h000000000);
            rd(nvd_pkg::ADDR_PULSE_COUNT, 33'h000000000);
            r = p ? 6'(6 + ($random(seed) & 1)) : 6'(49 + ($random(seed) & 7));
            apb(1'b1, nvd_pkg::ADDR_CLOCK_RATIO, {24'h000000, 1'b1, p[0], r});
            rd(nvd_pkg::ADDR_CLOCK_RATIO, {25'h0000001, p[0], r});
            apb(1'b1, nvd_pkg::ADDR_CLOCK_RATIO, {24'h000000, 1'b0, ~p[0], ~r});
            rd(nvd_pkg::ADDR_CLOCK_RATIO, {25'h0000001, p[0], r});
            @(posedge clk iff timingPulse === 1'b1);
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (timingPulse !== 1'b1);
            check(33'(n), 33'((r + 1) * (p ? 8 : 1)));
            kick <= 1'b1;
            opLen <= 16'($random(seed) & 3);
            @(posedge clk);
            kick <= 1'b0;
            n = 0;
            do
            begin
                @(posedge clk);
                n += int'(opBusy === 1'b1 && timingPulse === 1'b1);
            end
            while (opDone !== 1'b1);
            check(33'(n), 33'((opLen == 16'h0000) ? 16'h0001 : opLen));
            rd(12'h010, 33'h100000000);
            $display("Test with prescale %0d done", p);
        end
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
